// >>> rtl/spc_pkg.sv
package spc_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int SPC_ADDR_W = 8;
   localparam int SPC_DATA_W = 32;
   localparam int SPC_DI_N = 5;
   localparam int SPC_ST_W = 3;
   localparam int SPC_ANALOG_W = 8;
   localparam int SPC_TIMER_W = 16;
   localparam int SPC_SEL_W = 4;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SPC_OFF_CTRL = 8'h00;
   localparam logic [7:0] SPC_OFF_PAUSE = 8'h04;
   localparam logic [7:0] SPC_OFF_RESET = 8'h08;
   localparam logic [7:0] SPC_OFF_FORCE = 8'h0C;
   localparam logic [7:0] SPC_OFF_LSRC = 8'h10;
   localparam logic [7:0] SPC_OFF_LOPER = 8'h14;
   localparam logic [7:0] SPC_OFF_OUTS = 8'h18;
   localparam logic [7:0] SPC_OFF_STATUS = 8'h1C;
   localparam logic [7:0] SPC_OFF_TIMER = 8'h20;

   // ---------------------------------------------------------------
   // selector codes (two's complement, 4 bits)
   // ---------------------------------------------------------------
   localparam logic [3:0] SPC_SEL_NONE = 4'h0;
   localparam logic [3:0] SPC_SEL_DI_MAX = 4'h5;
   localparam logic [3:0] SPC_SEL_CONST = 4'h6;
   localparam logic [3:0] SPC_SEL_INV_MIN = 4'hB;
   localparam logic [3:0] SPC_SEL_INV_MAX = 4'hF;
   localparam logic [3:0] SPC_FORCE_MIN = 4'h1;
   localparam logic [3:0] SPC_FORCE_MAX = 4'h8;
   localparam logic [3:0] SPC_FORCE_DEF = 4'h1;
   localparam logic [2:0] SPC_FIRST_STATE = 3'h0;
   localparam int SPC_CTRL_RUN_BIT = 0;

   typedef enum logic [1:0] {
      SPC_OP_PASS = 2'h0,
      SPC_OP_AND = 2'h1,
      SPC_OP_OR = 2'h2,
      SPC_OP_XOR = 2'h3
   } spc_oper_t;

   typedef enum logic [2:0] {
      SPC_STOPPED = 3'b001,
      SPC_RUNNING = 3'b010,
      SPC_PAUSED = 3'b100
   } spc_run_t;

   typedef struct packed {
      logic [SPC_ANALOG_W-1:0] analog;
      logic transistor;
      logic relay;
   } spc_outs_t;

   typedef struct packed {
      logic stopped;
      logic logic_res;
      logic paused;
      logic [SPC_ST_W-1:0] state;
   } spc_status_t;
endpackage

// >>> rtl/spc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
   parameter int W = 5
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // spc_sync
`default_nettype wire

// >>> rtl/spc_top.sv
// Summary of operation
// R01 - pause selector code 6 holds pause asserted regardless of inputs
// R02 - while paused, timers and relay/transistor/analog outputs hold; only forcing moves state
// R03 - separate reset source selector, default no source
// R04 - accepted reset returns to first state, clears timers and outputs
// R05 - reset request ignored unless sequence program is stopped
// R06 - reset codes -1..-5 use inputs 1..5 inverted, low requests reset
// R07 - reset code 0 means no source, codes 1..5 use inputs non-inverted
// R08 - reset code 6 issues one request then reverts to no source
// R09 - forced target coded 1..8, default state one
// R10 - state goes to forced target only while paused and target written
// R11 - first logic value source combined with second value by operator
// R12 - combined result offered as state transition trigger
// R13 - first value codes -1..-5 inverted inputs, code 0 no value
// R14 - operator 0 pass, 1 AND, 2 OR, 3 XOR
// R15 - digital inputs synchronised once per cycle before use
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module spc_top
   import spc_pkg::*;
#(
   parameter int TIMER_W = SPC_TIMER_W
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [SPC_ADDR_W-1:0] PADDR,
   input wire logic [SPC_DATA_W-1:0] PWDATA,
   output logic [SPC_DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [SPC_DI_N-1:0] DIGITAL_INPUT,
   input wire logic LOGIC_VALUE_2,
   input wire logic STEP_REQ,
   input wire logic [SPC_ST_W-1:0] STEP_TARGET,
   output logic [SPC_ST_W-1:0] CURRENT_SEQUENCE_STATE,
   output logic LOGIC_RESULT_TRIGGER,
   output logic PAUSE_ACTIVE,
   output logic [TIMER_W-1:0] SEQUENCE_TIMER,
   output logic RELAY_OUTPUT,
   output logic TRANSISTOR_OUTPUT,
   output logic [SPC_ANALOG_W-1:0] ANALOG_OUTPUT
);
   // ---------------------------------------------------------------
   // selector decode
   // ---------------------------------------------------------------
   // codes outside -5..5 give no input level; callers add their own
   // constant codes on top
   function automatic logic sel_level(input logic [3:0] code, input logic [SPC_DI_N-1:0] di);
      logic [3:0] idx;
      idx = 4'h0;
      sel_level = 1'b0;
      if (code != SPC_SEL_NONE && code <= SPC_SEL_DI_MAX) begin
         idx = code - 4'h1;
         sel_level = di[idx[2:0]];
      end else if (code >= SPC_SEL_INV_MIN && code <= SPC_SEL_INV_MAX) begin
         idx = SPC_SEL_INV_MAX - code;
         sel_level = ~di[idx[2:0]];
      end
   endfunction

   function automatic logic addr_ok(input logic [SPC_ADDR_W-1:0] a);
      addr_ok = (a == SPC_OFF_CTRL) || (a == SPC_OFF_PAUSE) || (a == SPC_OFF_RESET) ||
                (a == SPC_OFF_FORCE) || (a == SPC_OFF_LSRC) || (a == SPC_OFF_LOPER) ||
                (a == SPC_OFF_OUTS) || (a == SPC_OFF_STATUS) || (a == SPC_OFF_TIMER);
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [SPC_DI_N-1:0] di_s;
   logic ready_q;
   logic [SPC_DATA_W-1:0] rdata_q;
   logic slverr_q;
   logic run_q;
   logic [3:0] pause_src_q;
   logic [3:0] reset_src_q;
   logic [3:0] force_q;
   logic [3:0] lsrc_q;
   spc_oper_t loper_q;
   spc_outs_t outs_stage_q;
   spc_outs_t outs_q;
   spc_run_t fsm_q;
   logic [SPC_ST_W-1:0] state_q;
   logic [TIMER_W-1:0] timer_q;
   logic pause_q;
   logic logic_q;
   logic access;
   logic xfer;
   logic wr;
   logic wr_reset;
   logic force_take;
   logic step_take;
   logic pause_w;
   logic rst_req;
   logic rst_acc;
   logic value1;
   logic logic_w;
   logic [3:0] force_code;
   logic [SPC_DATA_W-1:0] rdata_d;
   spc_status_t status_w;

   spc_sync #(.W(SPC_DI_N)) u_sync (
      .CLK(CLK),
      .RST(RST),
      .d(DIGITAL_INPUT),
      .q(di_s)
   ); // [R15]

   // ---------------------------------------------------------------
   // apb slave: one wait state, answer registered
   // ---------------------------------------------------------------
   assign access = PSEL & PENABLE;
   assign xfer = access & ready_q;
   assign wr = xfer & PWRITE;
   assign wr_reset = wr && (PADDR == SPC_OFF_RESET);
   assign force_code = PWDATA[3:0];

   always_comb begin
      status_w = '{stopped: (fsm_q == SPC_STOPPED), logic_res: logic_q, paused: pause_q, state: state_q};
      rdata_d = '0;
      if (PADDR == SPC_OFF_CTRL) begin
         rdata_d[SPC_CTRL_RUN_BIT] = run_q;
      end else if (PADDR == SPC_OFF_PAUSE) begin
         rdata_d[3:0] = pause_src_q;
      end else if (PADDR == SPC_OFF_RESET) begin
         rdata_d[3:0] = reset_src_q;
      end else if (PADDR == SPC_OFF_FORCE) begin
         rdata_d[3:0] = force_q;
      end else if (PADDR == SPC_OFF_LSRC) begin
         rdata_d[3:0] = lsrc_q;
      end else if (PADDR == SPC_OFF_LOPER) begin
         rdata_d[1:0] = loper_q;
      end else if (PADDR == SPC_OFF_OUTS) begin
         rdata_d[$bits(spc_outs_t)-1:0] = outs_stage_q;
      end else if (PADDR == SPC_OFF_STATUS) begin
         rdata_d[$bits(spc_status_t)-1:0] = status_w;
      end else if (PADDR == SPC_OFF_TIMER) begin
         rdata_d[TIMER_W-1:0] = timer_q;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ready_q <= 1'b0;
         rdata_q <= '0;
         slverr_q <= 1'b0;
      end else begin
         ready_q <= access & ~ready_q;
         if (access & ~ready_q) begin
            rdata_q <= PWRITE ? '0 : rdata_d;
            slverr_q <= ~addr_ok(PADDR);
         end
      end
   end

   // ---------------------------------------------------------------
   // parameter registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         run_q <= 1'b0;
         pause_src_q <= SPC_SEL_NONE;
         lsrc_q <= SPC_SEL_NONE;
         loper_q <= SPC_OP_PASS;
         force_q <= SPC_FORCE_DEF; // [R09]
      end else if (wr) begin
         if (PADDR == SPC_OFF_CTRL) begin
            run_q <= PWDATA[SPC_CTRL_RUN_BIT];
         end else if (PADDR == SPC_OFF_PAUSE) begin
            pause_src_q <= PWDATA[3:0];
         end else if (PADDR == SPC_OFF_LSRC) begin
            lsrc_q <= PWDATA[3:0];
         end else if (PADDR == SPC_OFF_LOPER) begin
            loper_q <= spc_oper_t'(PWDATA[1:0]);
         end else if (PADDR == SPC_OFF_FORCE && force_code >= SPC_FORCE_MIN && force_code <= SPC_FORCE_MAX) begin
            force_q <= force_code; // [R09]
         end
      end
   end

   // software write wins over the automatic revert so a fresh code is kept
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         reset_src_q <= SPC_SEL_NONE; // [R03]
      end else if (wr_reset) begin
         reset_src_q <= PWDATA[3:0];
      end else if (reset_src_q == SPC_SEL_CONST) begin
         reset_src_q <= SPC_SEL_NONE; // [R08]
      end
   end

   // ---------------------------------------------------------------
   // qualifiers
   // ---------------------------------------------------------------
   assign pause_w = (pause_src_q == SPC_SEL_CONST) | sel_level(pause_src_q, di_s); // [R01]
   assign rst_req = (reset_src_q == SPC_SEL_CONST) | sel_level(reset_src_q, di_s); // [R06] [R07] [R08]
   assign rst_acc = rst_req & (fsm_q == SPC_STOPPED); // [R05]
   assign force_take = wr && (PADDR == SPC_OFF_FORCE) && pause_w && !rst_acc &&
                       force_code >= SPC_FORCE_MIN && force_code <= SPC_FORCE_MAX; // [R10]
   assign step_take = STEP_REQ && (fsm_q == SPC_RUNNING) && !pause_w; // [R02]

   // ---------------------------------------------------------------
   // run state machine
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fsm_q <= SPC_STOPPED;
      end else begin
         case (fsm_q)
            SPC_STOPPED: begin
               if (run_q) begin
                  fsm_q <= pause_w ? SPC_PAUSED : SPC_RUNNING;
               end
            end
            SPC_RUNNING: begin
               if (!run_q) begin
                  fsm_q <= SPC_STOPPED;
               end else if (pause_w) begin
                  fsm_q <= SPC_PAUSED;
               end
            end
            SPC_PAUSED: begin
               if (!run_q) begin
                  fsm_q <= SPC_STOPPED;
               end else if (!pause_w) begin
                  fsm_q <= SPC_RUNNING;
               end
            end
            default: begin
               fsm_q <= SPC_STOPPED;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // sequence state and timer
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= SPC_FIRST_STATE;
      end else if (rst_acc) begin
         state_q <= SPC_FIRST_STATE; // [R04]
      end else if (force_take) begin
         state_q <= 3'(force_code - SPC_FORCE_MIN); // [R10]
      end else if (step_take) begin
         state_q <= STEP_TARGET;
      end
   end

   // timer wraps rather than saturates
   // forcing only happens in pause, where timers must hold, so it keeps the count
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         timer_q <= '0;
      end else if (rst_acc || step_take) begin
         timer_q <= '0; // [R04]
      end else if (fsm_q == SPC_RUNNING && !pause_w) begin
         timer_q <= timer_q + 1'b1; // [R02]
      end
   end

   // ---------------------------------------------------------------
   // relay, transistor and analog outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         outs_stage_q <= '0;
      end else if (rst_acc) begin
         outs_stage_q <= '0; // [R04]
      end else if (wr && PADDR == SPC_OFF_OUTS) begin
         outs_stage_q <= PWDATA[$bits(spc_outs_t)-1:0];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         outs_q <= '0;
      end else if (rst_acc) begin
         outs_q <= '0; // [R04]
      end else if (!pause_w) begin
         outs_q <= outs_stage_q; // [R02]
      end
   end

   // ---------------------------------------------------------------
   // first logic operation
   // ---------------------------------------------------------------
   assign value1 = sel_level(lsrc_q, di_s); // [R11] [R13]

   always_comb begin
      case (loper_q)
         SPC_OP_AND: logic_w = value1 & LOGIC_VALUE_2; // [R14]
         SPC_OP_OR: logic_w = value1 | LOGIC_VALUE_2; // [R14]
         SPC_OP_XOR: logic_w = value1 ^ LOGIC_VALUE_2; // [R14]
         default: logic_w = value1; // [R14]
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         logic_q <= 1'b0;
         pause_q <= 1'b0;
      end else begin
         logic_q <= logic_w; // [R12]
         pause_q <= pause_w;
      end
   end

   assign PRDATA = rdata_q;
   assign PREADY = ready_q;
   assign PSLVERR = slverr_q;
   assign CURRENT_SEQUENCE_STATE = state_q;
   assign LOGIC_RESULT_TRIGGER = logic_q;
   assign PAUSE_ACTIVE = pause_q;
   assign SEQUENCE_TIMER = timer_q;
   assign RELAY_OUTPUT = outs_q.relay;
   assign TRANSISTOR_OUTPUT = outs_q.transistor;
   assign ANALOG_OUTPUT = outs_q.analog;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_reset_accept;
      rst_req && fsm_q == SPC_STOPPED;
   endsequence

   sequence s_cleared;
      state_q == SPC_FIRST_STATE && timer_q == '0 && outs_q == '0;
   endsequence
   sequence s_reset_refused;
      rst_req && fsm_q != SPC_STOPPED && !force_take && !step_take;
   endsequence
   sequence s_single_pending;
      reset_src_q == SPC_SEL_CONST && !wr_reset;
   endsequence

   a_const_pause: assert property (pause_src_q == SPC_SEL_CONST |=> PAUSE_ACTIVE) // [R01]
      else $error("constant pause code did not assert pause");
   a_pause_hold: assert property (pause_w && !rst_acc |=> $stable(outs_q) && $stable(timer_q)) // [R02]
      else $error("outputs or timer moved while paused");
   a_reset_clears: assert property (s_reset_accept |=> s_cleared) // [R04]
      else $error("accepted reset did not clear state, timer and outputs");
   a_reset_stopped: assert property (s_reset_refused |=> $stable(state_q)) // [R05]
      else $error("reset acted while not stopped");
   a_inv_reset: assert property (reset_src_q == SPC_SEL_INV_MAX && !di_s[0] |-> rst_req) // [R06]
      else $error("inverted input low did not request reset");
   a_single_revert: assert property (s_single_pending |=> reset_src_q == SPC_SEL_NONE) // [R08]
      else $error("single reset code did not revert");
   a_force_target: assert property (force_take |=> state_q == 3'($past(force_code) - SPC_FORCE_MIN)) // [R10]
      else $error("forced state not reached");
   a_force_paused: assert property (!pause_w && !rst_acc && !step_take |=> $stable(state_q)) // [R10]
      else $error("state changed outside pause, step or reset");
   a_no_value: assert property (lsrc_q == SPC_SEL_NONE && loper_q == SPC_OP_PASS |=> !LOGIC_RESULT_TRIGGER) // [R13]
      else $error("no-source value gave a true result");
   a_xor_oper: assert property (loper_q == SPC_OP_XOR |=> logic_q == $past(value1 ^ LOGIC_VALUE_2)) // [R14]
      else $error("xor operator result wrong");
endmodule // spc_top
`default_nettype wire

// >>> bench/spc_switch_bank.sv
`timescale 1ns/100ps
`default_nettype none
module spc_switch_bank
   import spc_pkg::*;
(
   input wire logic clk,
   input wire logic [SPC_DI_N-1:0] level,
   output logic [SPC_DI_N-1:0] contact = 5'h00
);
   // -------------------------------------
   // switch contacts
   // -------------------------------------
   // contacts settle one clock after the bench moves them, like a slow switch
   always @(posedge clk) begin
      contact <= level;
   end
endmodule // spc_switch_bank
`default_nettype wire

// >>> bench/sequence_program_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module sequence_program_control_test
   import spc_pkg::*;
;
   // -------------------------------------
   // signals
   // -------------------------------------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic pen = 1'h0;
   logic pwr = 1'h0;
   logic v2 = 1'h0;
   logic step = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] level = 5'h00;
   logic [2:0] tgt = 3'h0;
   logic [31:0] prdata;
   logic pready, pslverr, trig, paused, relay, trans;
   logic [4:0] di;
   logic [2:0] state;
   logic [SPC_TIMER_W-1:0] timer;
   logic [7:0] analog;
   logic [9:0] outs;
   logic [31:0] seed = 32'h6164;
   logic [3:0] codes [12] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
   // reset source code, contact levels, reset expected
   logic [9:0] rcases [8] = '{{4'h1, 5'h01, 1'h1}, {4'h1, 5'h1E, 1'h0}, {4'h0, 5'h1F, 1'h0},
      {4'hF, 5'h00, 1'h1}, {4'hF, 5'h01, 1'h0}, {4'hB, 5'h0F, 1'h1}, {4'h5, 5'h10, 1'h1}, {4'h6, 5'h00, 1'h1}};
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   assign outs = {analog, trans, relay};

   spc_switch_bank contacts (.clk(clk), .level(level), .contact(di));

   spc_top #(.TIMER_W(SPC_TIMER_W)) uut (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DIGITAL_INPUT(di), .LOGIC_VALUE_2(v2), .STEP_REQ(step), .STEP_TARGET(tgt),
      .CURRENT_SEQUENCE_STATE(state), .LOGIC_RESULT_TRIGGER(trig), .PAUSE_ACTIVE(paused),
      .SEQUENCE_TIMER(timer), .RELAY_OUTPUT(relay), .TRANSISTOR_OUTPUT(trans), .ANALOG_OUTPUT(analog)
   );

   // -------------------------------------
   // helpers
   // -------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   function automatic logic sel_val(input logic [3:0] c, input logic [4:0] d);
      if (c >= 4'h1 && c <= 4'h5) return d[c - 4'h1];
      if (c >= 4'hB) return ~d[4'hF - c];
      return 1'h0;
   endfunction

   function automatic logic op_val(input logic [1:0] o, input logic a, input logic b);
      case (o)
         2'h1: return a & b;
         2'h2: return a | b;
         2'h3: return a ^ b;
         default: return a;
      endcase
   endfunction

   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      // pready is polled, then the wait is checked to be 2 cycles; only the bench timeout stops a hung slave
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      chk("pready wait", 32'h2, 32'(n));
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
      chk("write error", 32'h0, 32'(e));
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      chk(nm, x, r);
   endtask

   task automatic stepto(input logic [2:0] t);
      step <= 1'h1;
      tgt <= t;
      cyc(1);
      step <= 1'h0;
   endtask

   task automatic run_to(input logic [2:0] t);
      wr(SPC_OFF_CTRL, 32'h1);
      cyc(2);
      stepto(t);
      cyc(2);
      chk("stepped state", 32'(t), 32'(state));
      wr(SPC_OFF_CTRL, 32'h0);
      cyc(2);
   endtask

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         give_verdict();
      end
   end

   // -------------------------------------
   // sequence
   // -------------------------------------
   initial begin
      logic [3:0] c;
      logic [1:0] o;
      logic old;
      logic e;
      logic [31:0] r;
      logic [9:0] rc;
      logic [SPC_TIMER_W-1:0] t0;
      cyc(16);
      rst <= 1'h0;
      rd_chk("reset source default", SPC_OFF_RESET, 32'h0);
      rd_chk("force default", SPC_OFF_FORCE, 32'(SPC_FORCE_DEF));
      rd_chk("value source default", SPC_OFF_LSRC, 32'h0);
      apb(1'h0, 8'h40, 32'h0, r, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, r);
      for (int i = 0; i < 48; i++) begin
         seed = lfsr(seed);
         c = codes[i % 12];
         o = 2'((i / 12) % 4);
         v2 <= seed[5];
         wr(SPC_OFF_LSRC, 32'(c));
         wr(SPC_OFF_LOPER, 32'(o));
         wr(SPC_OFF_PAUSE, 32'(c));
         cyc(3);
         old = trig;
         level <= seed[4:0];
         cyc(2);
         chk("sync delay", 32'(old), 32'(trig));
         cyc(4);
         chk("logic result", 32'(op_val(o, sel_val(c, seed[4:0]), seed[5])), 32'(trig));
         chk("pause", 32'((c == SPC_SEL_CONST) | sel_val(c, seed[4:0])), 32'(paused));
      end
      wr(SPC_OFF_PAUSE, 32'h0);
      wr(SPC_OFF_CTRL, 32'h1);
      cyc(2);
      stepto(3'h4);
      wr(SPC_OFF_OUTS, 32'h2A5);
      cyc(3);
      chk("outputs", 32'h2A5, 32'(outs));
      chk("timer count", 32'h6, 32'(timer));
      wr(SPC_OFF_PAUSE, 32'(SPC_SEL_CONST));
      cyc(3);
      t0 = timer;
      wr(SPC_OFF_OUTS, 32'h15A);
      stepto(3'h1);
      cyc(3);
      chk("held outputs", 32'h2A5, 32'(outs));
      chk("held timer", 32'(t0), 32'(timer));
      chk("step in pause", 32'h4, 32'(state));
      wr(SPC_OFF_FORCE, 32'h3);
      cyc(1);
      chk("forced state", 32'h2, 32'(state));
      wr(SPC_OFF_FORCE, 32'h9);
      cyc(1);
      chk("bad force", 32'h2, 32'(state));
      wr(SPC_OFF_FORCE, 32'h8);
      cyc(1);
      chk("force to last", 32'h7, 32'(state));
      wr(SPC_OFF_PAUSE, 32'h0);
      cyc(3);
      wr(SPC_OFF_FORCE, 32'h4);
      cyc(2);
      chk("force unpaused", 32'h7, 32'(state));
      chk("released outputs", 32'h15A, 32'(outs));
      level <= 5'h01;
      wr(SPC_OFF_RESET, 32'h1);
      cyc(4);
      chk("reset while running", 32'h7, 32'(state));
      wr(SPC_OFF_CTRL, 32'h0);
      cyc(4);
      chk("reset once stopped", 32'h0, 32'(state));
      wr(SPC_OFF_RESET, 32'h0);
      for (int i = 0; i < 8; i++) begin
         rc = rcases[i];
         level <= rc[5:1];
         run_to(3'h5);
         wr(SPC_OFF_OUTS, 32'h3FF);
         cyc(3);
         wr(SPC_OFF_RESET, 32'(rc[9:6]));
         cyc(3);
         chk("reset state", rc[0] ? 32'h0 : 32'h5, 32'(state));
         chk("reset outputs", rc[0] ? 32'h0 : 32'h3FF, 32'(outs));
         if (rc[0] && rc[9:6] != SPC_SEL_CONST) chk("reset timer", 32'h0, 32'(timer));
         rd_chk("reset source", SPC_OFF_RESET, rc[9:6] == SPC_SEL_CONST ? 32'h0 : 32'(rc[9:6]));
         wr(SPC_OFF_RESET, 32'h0);
      end
      give_verdict();
   end
endmodule // sequence_program_control_test
`default_nettype wire
